// *** sefs_chk.sv ***
// Checker on the ports of sefs_top, attached to every instance by bind.
// Assumes one clock with a synchronous active-high reset.
module sefs_chk #(
	parameter int POS_W       = 24,
	parameter int SPD_W       = 16,
	parameter bit POS_VARIANT = 1'b1
)(
	input wire logic                    clk,
	input wire logic                    rst,
	input wire logic                    servo_on_n,
	input wire logic [15:0]             function_switch_word,
	input wire logic [POS_W-1:0]        in_position_window,
	input wire logic [SPD_W-1:0]        speed_match_window,
	input wire logic signed [POS_W-1:0] pos_error,
	input wire logic signed [SPD_W-1:0] speed_ref,
	input wire logic signed [SPD_W-1:0] speed_act,
	input wire logic                    motor_moving,
	input wire logic                    servo_on,
	input wire logic                    power_enable,
	input wire logic                    brake_after_stop,
	input wire logic                    dyn_brake,
	input wire logic                    stop_coast,
	input wire logic                    status_n,
	input wire logic                    in_position_flag_n,
	input wire logic                    speed_match_flag_n
);
	logic signed [SPD_W:0] sd;
	logic                  ip;
	logic                  sm;
	logic                  stopreq;
	assign sd = speed_ref - speed_act;
	assign ip = POS_VARIANT && (((pos_error < 0) ? -pos_error : pos_error) < in_position_window);
	assign sm = !POS_VARIANT && (((sd < 0) ? -sd : sd) <= ((speed_match_window >
		sefs_pkg::SPD_WIN_MAX) ? sefs_pkg::SPD_WIN_MAX : speed_match_window));
	assign stopreq = servo_on && servo_on_n && !function_switch_word[0] && motor_moving;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_ON_HOLD: assert property (servo_on && !servo_on_n |=> servo_on)
		else $error("servo dropped");
	AST_OFF: assert property (servo_on_n && !function_switch_word[0] |=> !servo_on)
		else $error("servo not off");
	AST_IGNORE: assert property (servo_on && function_switch_word[0] |=> servo_on)
		else $error("enable not ignored");
	AST_BRAKE: assert property (stopreq && !$past(rst) && $stable(function_switch_word[7:6])
		&& function_switch_word[7:6] == 2'h0 |=> dyn_brake && !stop_coast) else $error("no brake");
	AST_COAST: assert property (stopreq && !$past(rst) && $stable(function_switch_word[7:6])
		&& function_switch_word[7] |=> stop_coast && !servo_on) else $error("no coast");
	AST_INPOS: assert property (1'b1 |=> in_position_flag_n == !$past(ip))
		else $error("in position flag");
	AST_SPEED: assert property (!$past(rst) && $stable(speed_match_window)
		|=> speed_match_flag_n == !$past(sm)) else $error("speed match flag");
	AST_PIN: assert property (status_n ==
		(POS_VARIANT ? in_position_flag_n : speed_match_flag_n)) else $error("shared pin");
	AST_UNUSED: assert property (POS_VARIANT ? speed_match_flag_n : in_position_flag_n)
		else $error("flag of other variant");
	AST_POWER: assert property (power_enable == servo_on)
		else $error("power not following servo state");
	AST_HOLD: assert property (brake_after_stop |-> dyn_brake && !servo_on)
		else $error("brake hold outside servo off");
	cover property (stopreq);
	cover property (!in_position_flag_n);
	cover property (!speed_match_flag_n && speed_match_window > sefs_pkg::SPD_WIN_MAX);
endmodule // sefs_chk

bind sefs_top sefs_chk #(.POS_W(POS_W), .SPD_W(SPD_W), .POS_VARIANT(POS_VARIANT)) chk (.clk, .rst,
	.servo_on_n, .function_switch_word, .in_position_window, .speed_match_window, .pos_error,
	.speed_ref, .speed_act, .motor_moving, .servo_on, .power_enable, .brake_after_stop,
	.dyn_brake, .stop_coast, .status_n,
	.in_position_flag_n, .speed_match_flag_n);

// *** sefs_cmp.sv ***
// Window comparators for in-position and speed-match; results are combinational.
// Assumes the caller registers the results before they reach any pin.
module sefs_cmp #(
	parameter int POS_W = 24,
	parameter int SPD_W = 16
)(
	sefs_cmp_if.cmp c
);
	logic [POS_W-1:0] pos_mag;
	logic [SPD_W:0]   spd_diff;
	logic [SPD_W:0]   spd_mag;

	always_comb
	begin
		pos_mag  = c.pos_error[POS_W-1] ? POS_W'(-c.pos_error) : POS_W'(c.pos_error);
		spd_diff = (SPD_W+1)'($signed({c.speed_ref[SPD_W-1], c.speed_ref})
			- $signed({c.speed_act[SPD_W-1], c.speed_act}));
		spd_mag  = spd_diff[SPD_W] ? (SPD_W+1)'(-spd_diff) : spd_diff;
		// Error counted in reference units after gear scaling, strictly below window.
		c.in_pos      = pos_mag < c.pos_window;
		c.speed_match = spd_mag <= {1'b0, c.speed_window};
	end
endmodule // sefs_cmp

// *** sefs_cmp_if.sv ***
// Interface carrying threshold comparison inputs and results between the top and comparator.
// Assumes both ends sit in the same clock domain.
interface sefs_cmp_if #(parameter int POS_W = 24, parameter int SPD_W = 16);
	logic signed [POS_W-1:0] pos_error;
	logic        [POS_W-1:0] pos_window;
	logic signed [SPD_W-1:0] speed_ref;
	logic signed [SPD_W-1:0] speed_act;
	logic        [SPD_W-1:0] speed_window;
	logic                    in_pos;
	logic                    speed_match;

	modport top (output pos_error, pos_window, speed_ref, speed_act, speed_window,
		input in_pos, speed_match);
	modport cmp (input pos_error, pos_window, speed_ref, speed_act, speed_window,
		output in_pos, speed_match);
endinterface

// *** sefs_host.sv ***
// Host controller model on the enable contact and the speed reference.
// Assumes the bench steps its commands at the falling clock edge.
module sefs_host (
	input  wire logic               want_on,
	input  wire logic signed [15:0] target,
	output logic                    servo_on_n,
	output logic signed [15:0]      speed_ref
);
	// An open contact reads high through the drive's pull-up.
	assign servo_on_n = !want_on;
	// Motion is started and stopped by the reference and the contact together, both following want_on.
	assign speed_ref = want_on ? target : 16'sh0000;
endmodule // sefs_host

// *** sefs_pkg.sv ***
// Package for the servo enable and status flag block: field positions, defaults, widths.
// Assumes a single 125 MHz clock domain; all inputs are synchronous to it.
package sefs_pkg;
	localparam int FSW_W            = 16;
	localparam int FSW_IGNORE_EN    = 0;
	localparam int FSW_STOP_LO      = 6;
	localparam int FSW_STOP_HI      = 7;
	localparam logic [15:0] FSW_RESET = 16'h0000;
	localparam int POS_W            = 24;
	localparam int SPD_W            = 16;
	localparam logic [15:0] SPD_WIN_MAX     = 16'h0064;
	localparam logic [15:0] SPD_WIN_DEFAULT = 16'h000a;
	localparam logic [23:0] POS_WIN_DEFAULT = 24'h00000a;

	typedef enum logic [1:0]
	{
		SEFS_STOP_DB_HOLD,
		SEFS_STOP_DB_FREE,
		SEFS_STOP_COAST_DB,
		SEFS_STOP_COAST_FREE
	} sefs_stop_t;

	typedef enum logic [1:0]
	{
		SEFS_ST_OFF,
		SEFS_ST_ON,
		SEFS_ST_STOPPING
	} sefs_state_t;
endpackage

// *** sefs_top.sv ***
// Servo enable handling and in-position / speed-match status output for a servo drive.
// Assumes a 125 MHz clock, synchronous active-high reset, and contact inputs already
// synchronous to the clock. Motion quantities come from the drive's control loop.
module sefs_top #(
	parameter int          POS_W   = sefs_pkg::POS_W,
	parameter int          SPD_W   = sefs_pkg::SPD_W,
	parameter bit          POS_VARIANT = 1'b1
)(
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    servo_on_n,
	input  wire logic [sefs_pkg::FSW_W-1:0] function_switch_word,
	input  wire logic [POS_W-1:0]        in_position_window,
	input  wire logic [SPD_W-1:0]        speed_match_window,
	input  wire logic signed [POS_W-1:0] pos_error,
	input  wire logic signed [SPD_W-1:0] speed_ref,
	input  wire logic signed [SPD_W-1:0] speed_act,
	input  wire logic                    motor_moving,
	output logic                         servo_on,
	output logic                         power_enable,
	output logic                         dyn_brake,
	output logic                         brake_after_stop,
	output logic                         stop_coast,
	output logic                         status_n,
	output logic                         in_position_flag_n,
	output logic                         speed_match_flag_n
);
	sefs_cmp_if #(.POS_W(POS_W), .SPD_W(SPD_W)) cif ();

	sefs_pkg::sefs_state_t state_reg;
	sefs_pkg::sefs_state_t state_next;
	logic [1:0]       stop_sel_reg;
	logic [1:0]       stop_sel_next;
	logic [SPD_W-1:0] spd_win_reg;
	logic [SPD_W-1:0] spd_win_next;
	logic             servo_on_reg;
	logic             servo_on_next;
	logic             power_reg;
	logic             power_next;
	logic             db_reg;
	logic             db_next;
	logic             hold_reg;
	logic             hold_next;
	logic             coast_reg;
	logic             coast_next;
	logic             inpos_n_reg;
	logic             inpos_n_next;
	logic             vcmp_n_reg;
	logic             vcmp_n_next;
	logic             status_n_reg;
	logic             status_n_next;
	logic             enable_req;

	// Out-of-range window settings are clamped rather than rejected, so a bad
	// setting narrows to the widest legal band instead of disabling the flag.
	function automatic logic [SPD_W-1:0] clamp_spd(input logic [SPD_W-1:0] v);
		if (v > SPD_W'(sefs_pkg::SPD_WIN_MAX))
			clamp_spd = SPD_W'(sefs_pkg::SPD_WIN_MAX);
		else
			clamp_spd = v;
	endfunction

	assign cif.pos_error    = pos_error;
	assign cif.pos_window   = in_position_window;
	assign cif.speed_ref    = speed_ref;
	assign cif.speed_act    = speed_act;
	assign cif.speed_window = spd_win_reg;

	sefs_cmp #(.POS_W(POS_W), .SPD_W(SPD_W)) u_cmp
	(
		.c (cif.cmp)
	);

	always_comb
	begin
		// Low input requests servo-on; the switch bit forces it on regardless.
		enable_req = function_switch_word[sefs_pkg::FSW_IGNORE_EN] | ~servo_on_n;
		stop_sel_next = function_switch_word[sefs_pkg::FSW_STOP_HI:sefs_pkg::FSW_STOP_LO];
		spd_win_next  = clamp_spd(speed_match_window);
		state_next    = state_reg;
		case (state_reg)
			sefs_pkg::SEFS_ST_OFF:
			begin
				if (enable_req)
					state_next = sefs_pkg::SEFS_ST_ON;
			end
			sefs_pkg::SEFS_ST_ON:
			begin
				if (!enable_req)
					state_next = motor_moving ? sefs_pkg::SEFS_ST_STOPPING
						: sefs_pkg::SEFS_ST_OFF;
			end
			sefs_pkg::SEFS_ST_STOPPING:
			begin
				// A re-enable during the stop is not honoured until the motor is still,
				// so the stopping method always completes.
				if (!motor_moving)
					state_next = sefs_pkg::SEFS_ST_OFF;
			end
			default:
			begin
				state_next = sefs_pkg::SEFS_ST_OFF;
			end
		endcase

		servo_on_next = (state_next == sefs_pkg::SEFS_ST_ON);
		power_next    = servo_on_next;
		db_next       = 1'b0;
		coast_next    = 1'b0;
		hold_next     = 1'b0;
		if (state_next != sefs_pkg::SEFS_ST_ON)
		begin
			case (sefs_pkg::sefs_stop_t'(stop_sel_reg))
				sefs_pkg::SEFS_STOP_DB_HOLD:
				begin
					db_next   = 1'b1;
					hold_next = (state_next == sefs_pkg::SEFS_ST_OFF);
				end
				sefs_pkg::SEFS_STOP_DB_FREE:
				begin
					db_next    = (state_next == sefs_pkg::SEFS_ST_STOPPING);
					coast_next = (state_next == sefs_pkg::SEFS_ST_OFF);
				end
				sefs_pkg::SEFS_STOP_COAST_DB:
				begin
					coast_next = (state_next == sefs_pkg::SEFS_ST_STOPPING);
					db_next    = (state_next == sefs_pkg::SEFS_ST_OFF);
				end
				sefs_pkg::SEFS_STOP_COAST_FREE:
				begin
					coast_next = 1'b1;
				end
				default:
				begin
					db_next = 1'b1;
				end
			endcase
		end

		// Comparisons run every cycle; the pin follows one cycle later.
		inpos_n_next = ~(POS_VARIANT & cif.in_pos);
		vcmp_n_next  = ~(~POS_VARIANT & cif.speed_match);
		status_n_next = POS_VARIANT ? inpos_n_next : vcmp_n_next;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg    <= sefs_pkg::SEFS_ST_OFF;
			stop_sel_reg <= sefs_pkg::FSW_RESET[sefs_pkg::FSW_STOP_HI:sefs_pkg::FSW_STOP_LO];
			spd_win_reg  <= SPD_W'(sefs_pkg::SPD_WIN_DEFAULT);
			servo_on_reg <= 1'b0;
			power_reg    <= 1'b0;
			db_reg       <= 1'b1;
			hold_reg     <= 1'b0;
			coast_reg    <= 1'b0;
			inpos_n_reg  <= 1'b1;
			vcmp_n_reg   <= 1'b1;
			status_n_reg <= 1'b1;
		end
		else
		begin
			state_reg    <= state_next;
			stop_sel_reg <= stop_sel_next;
			spd_win_reg  <= spd_win_next;
			servo_on_reg <= servo_on_next;
			power_reg    <= power_next;
			db_reg       <= db_next;
			hold_reg     <= hold_next;
			coast_reg    <= coast_next;
			inpos_n_reg  <= inpos_n_next;
			vcmp_n_reg   <= vcmp_n_next;
			status_n_reg <= status_n_next;
		end
	end

	assign servo_on           = servo_on_reg;
	assign power_enable       = power_reg;
	assign dyn_brake          = db_reg;
	assign brake_after_stop   = hold_reg;
	assign stop_coast         = coast_reg;
	assign status_n           = status_n_reg;
	assign in_position_flag_n = inpos_n_reg;
	assign speed_match_flag_n = vcmp_n_reg;
endmodule // sefs_top

// *** sefs_top_bench.sv ***
// Self-checking bench: position and speed variants fed the same random contact traffic.
// Assumes the host model drives the enable contact and the speed reference.
module sefs_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               want_on = 1'b0;
	logic               motor_moving = 1'b0;
	logic [15:0]        function_switch_word = 16'h0000;
	logic [23:0]        in_position_window = 24'h000000;
	logic [15:0]        speed_match_window = 16'h0000;
	logic [15:0]        sw_prev;
	logic signed [23:0] pos_error = 24'sh000000;
	logic signed [15:0] target = 16'sh0000;
	logic signed [15:0] speed_act = 16'sh0000;
	logic signed [15:0] speed_ref;
	logic               servo_on_n;
	logic [1:0]         on, brk, st, ipn, smn, pw;
	logic               ip_exp;
	int                 fails = 0;
	int                 comparisons = 0;
	always #4 clk = ~clk;
	sefs_host host (.want_on, .target, .servo_on_n, .speed_ref);
	for (genvar g = 0; g < 2; g++)
	begin : v
		sefs_top #(.POS_VARIANT(g == 0)) dut (.clk, .rst, .servo_on_n, .function_switch_word,
			.in_position_window, .speed_match_window, .pos_error, .speed_ref, .speed_act,
			.motor_moving, .servo_on(on[g]), .power_enable(pw[g]), .dyn_brake(brk[g]),
			.brake_after_stop(), .stop_coast(), .status_n(st[g]),
			.in_position_flag_n(ipn[g]), .speed_match_flag_n(smn[g]));
	end
	function automatic logic exp_sm(logic signed [15:0] r, logic signed [15:0] a, logic [15:0] w);
		logic signed [16:0] d;
		d = r - a;
		if (d < 0)
			d = -d;
		return d <= ((w > sefs_pkg::SPD_WIN_MAX) ? sefs_pkg::SPD_WIN_MAX : w);
	endfunction
	task automatic chk(logic got, logic exp, string m);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		void'($urandom(46031));
		repeat (5) @(negedge clk);
		rst = 1'b0;
		chk(on[0] | ~brk[0], 1'b0, "reset state");
		chk(st[0] & st[1], 1'b1, "reset flags");
		sw_prev = sefs_pkg::SPD_WIN_DEFAULT;
		for (int i = 0; i < 400; i++)
		begin
			want_on = ($urandom % 4) != 0;
			motor_moving = 1'($urandom);
			function_switch_word = {8'h00, 2'($urandom), 5'h00, ($urandom % 8) == 0};
			in_position_window = 24'($urandom % 8);
			speed_match_window = 16'($urandom % 128);
			pos_error = $signed(24'($urandom % 17)) - 24'sd8;
			target = $signed(16'($urandom % 300)) - 16'sd150;
			speed_act = target + $signed(16'($urandom % 260)) - 16'sd130;
			// Boundary cases: error equal to the window, speed gap of exactly the clamp value.
			if (i % 16 == 0)
			begin
				want_on = 1'b1;
				pos_error = in_position_window;
				speed_act = target - 16'sd100;
			end
			@(negedge clk);
			ip_exp = (pos_error < 0 ? -pos_error : pos_error) < in_position_window;
			chk(ipn[0], !ip_exp, "in pos");
			chk(st[0], ipn[0], "position pin");
			chk(smn[0] & ipn[1], 1'b1, "unused flags");
			chk(smn[1], !exp_sm(speed_ref, speed_act, sw_prev), "speed match");
			chk(st[1], smn[1], "speed pin");
			chk(pw[0], on[0], "power enable");
			if (servo_on_n && !function_switch_word[0])
				chk(on[0], 1'b0, "servo off");
			sw_prev = speed_match_window;
		end
		close_out();
	end
	initial
	begin
		#20000;
		fails++;
		close_out();
	end
endmodule // sefs_top_bench
